// [verilog/irq_bank_defines.svh]
// Register offsets, field positions, reset values of the interrupt flag bank
// Included by the package users; holds definitions only
`ifndef IRQ_BANK_DEFINES_SVH
`define IRQ_BANK_DEFINES_SVH

`define OFF_EDGE_SELECT 8'h00
`define OFF_IRQ_CTRL_ZERO 8'h04
`define OFF_IRQ_CTRL_ONE 8'h08
`define OFF_IRQ_CTRL_TWO 8'h0c
`define OFF_IRQ_CTRL_THREE 8'h10
`define OFF_SHARED_SOURCE_ZERO 8'h14
`define OFF_SERVICE_CTRL 8'h18
`define OFF_SYS_STATUS 8'h1c
`define OFF_SYS_CLEAR 8'h20
`define OFF_SYS_ENABLE 8'h24

`define RESET_BYTE 8'h00

`define MASK_EDGE_SELECT 8'h0f
`define MASK_IRQ_CTRL_ZERO 8'h7f
`define MASK_IRQ_CTRL_ONE 8'hee
`define MASK_IRQ_CTRL_TWO 8'hff
`define MASK_IRQ_CTRL_THREE 8'hdd
`define MASK_SHARED_SOURCE_ZERO 8'h33

`define BIT_GLOBAL_EN 0
`define BIT_PIN0_EN 1
`define BIT_PIN1_EN 2
`define BIT_OC_EN 3
`define BIT_PIN0_FLAG 4
`define BIT_PIN1_FLAG 5
`define BIT_OC_FLAG 6
`define BIT_HOT_EN 1
`define BIT_IR_EN 2
`define BIT_ADC_EN 3
`define BIT_HOT_FLAG 5
`define BIT_IR_FLAG 6
`define BIT_ADC_FLAG 7
`define BIT_LOW_EN 0
`define BIT_EEP_EN 2
`define BIT_G4_EN 3
`define BIT_LOW_FLAG 4
`define BIT_EEP_FLAG 6
`define BIT_G4_FLAG 7
`define BIT_TC_P_EN 0
`define BIT_TC_A_EN 1
`define BIT_TC_P_FLAG 4
`define BIT_TC_A_FLAG 5
`define LSB_PIN0_EDGE 0
`define LSB_PIN1_EDGE 2

`define SRC_COUNT 16
`endif

// [verilog/irq_bank_pkg.sv]
// Types shared by the interrupt flag bank files
package irq_bank_pkg;
  typedef enum logic [1:0] {
    EDGE_OFF,
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } edge_mode_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRESP,
    BUS_RRESP
  } bus_state_t;
endpackage

// [verilog/pin_edge_detect.sv]
// Edge detector for one external interrupt pin
// Assumes the pin is already synchronous to clock
`timescale 1ns/10ps
module pin_edge_detect (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Pin and mode
  input wire logic pin,
  input wire irq_bank_pkg::edge_mode_t mode,
  // Result
  output logic hit
);
  import irq_bank_pkg::*;

  logic last;
  logic next_last;

  always_comb begin
    next_last = pin;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      last <= 1'b0;
    end else begin
      last <= next_last;
    end
  end

  always_comb begin
    case (mode)
      EDGE_RISE: hit = pin & ~last;
      EDGE_FALL: hit = ~pin & last;
      EDGE_BOTH: hit = pin ^ last;
      default: hit = 1'b0;
    endcase
  end
endmodule

// [verilog/irq_flag_bank.sv]
// Interrupt request flag and enable bank with AXI4-Lite register access
// Assumes event inputs are one-cycle pulses synchronous to clock
//
// Behaviour
// - Bits 3:2 of edge select choose pin1 trigger: off, rise, fall, both.
// - Bits 1:0 of edge select choose pin0 trigger with same encoding.
// - Bit 0 of control zero is global enable gating all requests.
// - Control zero: over-current, pin1, pin0 flags 6:4, enables 3:1.
// - Control one: adc, ir, heat flags 7:5, enables 3:1; bits 4,0 unused.
// - Control two: group 3..0 flags in 7:4, enables 3:0.
// - Control three: group4, eeprom, low supply flags 7,6,4; enables 3,2,0.
// - Shared source zero: timer match a/p flags 5:4, enables 1:0.
// - Unimplemented bits read zero and ignore writes.
// - Hardware sets flags on events; software reads and writes all bits.
// - A flag with its enable clear is kept but raises no request.
// - Service clears the global enable; new events still set flags.
// - Pin flags set on selected edge, cleared when that pin is serviced.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "irq_bank_defines.svh"
module irq_flag_bank (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External pins
  input wire logic pin0,
  input wire logic pin1,
  // Peripheral events
  input wire logic overcurrent_event,
  input wire logic overheat_event,
  input wire logic ir_sense_event,
  input wire logic adc_done_event,
  input wire logic eeprom_write_event,
  input wire logic low_supply_event,
  input wire logic timer_c_match_a_event,
  input wire logic timer_c_match_p_event,
  input wire logic [3:1] group_event,
  // Core sequencer
  output logic core_irq_request,
  input wire logic service_ack,
  input wire logic [3:0] service_source,
  // System interrupt
  output logic irq
);
  import irq_bank_pkg::*;

  logic [7:0] edge_select, next_edge_select;
  logic [7:0] irq_ctrl_zero, next_irq_ctrl_zero;
  logic [7:0] irq_ctrl_one, next_irq_ctrl_one;
  logic [7:0] irq_ctrl_two, next_irq_ctrl_two;
  logic [7:0] irq_ctrl_three, next_irq_ctrl_three;
  logic [7:0] shared_source_zero, next_shared_source_zero;
  logic [1:0] sys_status, next_sys_status;
  logic [1:0] sys_enable, next_sys_enable;
  logic pin0_hit, pin1_hit;
  logic [7:0] wbyte;
  logic wr_fire, rd_fire, aw_taken, w_taken, next_aw_taken, next_w_taken;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] wdata_hold, next_wdata_hold;
  logic wstrb0_hold, next_wstrb0_hold;
  logic [31:0] rdata, next_rdata;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  bus_state_t state, next_state;
  logic [8:0] pending;
  logic group0_src;

  // ----------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------
  pin_edge_detect u_pin0 (
    .clock(clock),
    .resetn(resetn),
    .pin(pin0),
    .mode(edge_mode_t'(edge_select[`LSB_PIN0_EDGE +: 2])),
    .hit(pin0_hit)
  );

  pin_edge_detect u_pin1 (
    .clock(clock),
    .resetn(resetn),
    .pin(pin1),
    .mode(edge_mode_t'(edge_select[`LSB_PIN1_EDGE +: 2])),
    .hit(pin1_hit)
  );

  // ----------------------------------------------------------------
  // Request gating
  // ----------------------------------------------------------------
  // Service source order: 0 pin0, 1 pin1, 2 oc, 3 heat, 4 ir, 5 adc,
  // 6..8 groups 0..2 (group 3,4 at 9,10 below), 11 eeprom, 12 low
  logic [12:0] req_vec;
  always_comb begin
    req_vec = 13'h0000;
    req_vec[0] = irq_ctrl_zero[`BIT_PIN0_FLAG] & irq_ctrl_zero[`BIT_PIN0_EN];
    req_vec[1] = irq_ctrl_zero[`BIT_PIN1_FLAG] & irq_ctrl_zero[`BIT_PIN1_EN];
    req_vec[2] = irq_ctrl_zero[`BIT_OC_FLAG] & irq_ctrl_zero[`BIT_OC_EN];
    req_vec[3] = irq_ctrl_one[`BIT_HOT_FLAG] & irq_ctrl_one[`BIT_HOT_EN];
    req_vec[4] = irq_ctrl_one[`BIT_IR_FLAG] & irq_ctrl_one[`BIT_IR_EN];
    req_vec[5] = irq_ctrl_one[`BIT_ADC_FLAG] & irq_ctrl_one[`BIT_ADC_EN];
    req_vec[6] = irq_ctrl_two[4] & irq_ctrl_two[0];
    req_vec[7] = irq_ctrl_two[5] & irq_ctrl_two[1];
    req_vec[8] = irq_ctrl_two[6] & irq_ctrl_two[2];
    req_vec[9] = irq_ctrl_two[7] & irq_ctrl_two[3];
    req_vec[10] = irq_ctrl_three[`BIT_G4_FLAG] & irq_ctrl_three[`BIT_G4_EN];
    req_vec[11] = irq_ctrl_three[`BIT_EEP_FLAG] & irq_ctrl_three[`BIT_EEP_EN];
    req_vec[12] = irq_ctrl_three[`BIT_LOW_FLAG] & irq_ctrl_three[`BIT_LOW_EN];
    core_irq_request = irq_ctrl_zero[`BIT_GLOBAL_EN] & (|req_vec);
  end

  assign group0_src =
    (shared_source_zero[`BIT_TC_A_FLAG] & shared_source_zero[`BIT_TC_A_EN]) |
    (shared_source_zero[`BIT_TC_P_FLAG] & shared_source_zero[`BIT_TC_P_EN]);

  // ----------------------------------------------------------------
  // AXI4-Lite handshake
  // ----------------------------------------------------------------
  assign s_axi_awready = (state == BUS_IDLE) & ~aw_taken;
  assign s_axi_wready = (state == BUS_IDLE) & ~w_taken;
  // Read waits while a write is offered, so a taken read is never dropped
  assign s_axi_arready = (state == BUS_IDLE) & ~aw_taken & ~w_taken & ~s_axi_awvalid &
    ~s_axi_wvalid;
  assign s_axi_bvalid = (state == BUS_WRESP);
  assign s_axi_rvalid = (state == BUS_RRESP);
  assign s_axi_bresp = bresp;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;

  logic got_aw, got_w;
  logic [7:0] waddr;
  logic [31:0] wdata_now;
  logic wstrb0_now;
  logic addr_ok_w, addr_ok_r;
  always_comb begin
    got_aw = aw_taken | (s_axi_awvalid & s_axi_awready);
    got_w = w_taken | (s_axi_wvalid & s_axi_wready);
    waddr = aw_taken ? aw_addr : s_axi_awaddr;
    wdata_now = w_taken ? wdata_hold : s_axi_wdata;
    wstrb0_now = w_taken ? wstrb0_hold : s_axi_wstrb[0];
    wr_fire = (state == BUS_IDLE) & got_aw & got_w;
    rd_fire = s_axi_arvalid & s_axi_arready;
    wbyte = wdata_now[7:0];
    addr_ok_w = (waddr[1:0] == 2'h0) & (waddr <= `OFF_SYS_ENABLE);
    addr_ok_r = (s_axi_araddr[1:0] == 2'h0) & (s_axi_araddr <= `OFF_SYS_ENABLE);
  end

  always_comb begin
    next_state = state;
    next_aw_taken = aw_taken;
    next_w_taken = w_taken;
    next_aw_addr = aw_addr;
    next_wdata_hold = wdata_hold;
    next_wstrb0_hold = wstrb0_hold;
    next_bresp = bresp;
    next_rresp = rresp;
    next_rdata = rdata;
    case (state)
      BUS_IDLE: begin
        if (s_axi_awvalid & s_axi_awready) begin
          next_aw_taken = 1'b1;
          next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          next_w_taken = 1'b1;
          next_wdata_hold = s_axi_wdata;
          next_wstrb0_hold = s_axi_wstrb[0];
        end
        if (wr_fire) begin
          next_state = BUS_WRESP;
          next_aw_taken = 1'b0;
          next_w_taken = 1'b0;
          next_bresp = addr_ok_w ? 2'h0 : 2'h2;
        end else if (rd_fire) begin
          next_state = BUS_RRESP;
          next_rresp = addr_ok_r ? 2'h0 : 2'h2;
          next_rdata = 32'h00000000;
          if (s_axi_araddr == `OFF_EDGE_SELECT) begin
            next_rdata[7:0] = edge_select;
          end else if (s_axi_araddr == `OFF_IRQ_CTRL_ZERO) begin
            next_rdata[7:0] = irq_ctrl_zero;
          end else if (s_axi_araddr == `OFF_IRQ_CTRL_ONE) begin
            next_rdata[7:0] = irq_ctrl_one;
          end else if (s_axi_araddr == `OFF_IRQ_CTRL_TWO) begin
            next_rdata[7:0] = irq_ctrl_two;
          end else if (s_axi_araddr == `OFF_IRQ_CTRL_THREE) begin
            next_rdata[7:0] = irq_ctrl_three;
          end else if (s_axi_araddr == `OFF_SHARED_SOURCE_ZERO) begin
            next_rdata[7:0] = shared_source_zero;
          end else if (s_axi_araddr == `OFF_SERVICE_CTRL) begin
            next_rdata[0] = core_irq_request;
          end else if (s_axi_araddr == `OFF_SYS_STATUS) begin
            next_rdata[1:0] = sys_status;
          end else if (s_axi_araddr == `OFF_SYS_ENABLE) begin
            next_rdata[1:0] = sys_enable;
          end
        end
      end
      BUS_WRESP: begin
        if (s_axi_bready) begin
          next_state = BUS_IDLE;
        end
      end
      BUS_RRESP: begin
        if (s_axi_rready) begin
          next_state = BUS_IDLE;
        end
      end
      default: next_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= BUS_IDLE;
      aw_taken <= 1'b0;
      w_taken <= 1'b0;
      aw_addr <= 8'h00;
      wdata_hold <= 32'h00000000;
      wstrb0_hold <= 1'b0;
      bresp <= 2'h0;
      rresp <= 2'h0;
      rdata <= 32'h00000000;
    end else begin
      state <= next_state;
      aw_taken <= next_aw_taken;
      w_taken <= next_w_taken;
      aw_addr <= next_aw_addr;
      wdata_hold <= next_wdata_hold;
      wstrb0_hold <= next_wstrb0_hold;
      bresp <= next_bresp;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic wr_en;
  logic svc;
  always_comb begin
    wr_en = wr_fire & wstrb0_now;
    svc = service_ack;
    next_edge_select = edge_select;
    next_irq_ctrl_zero = irq_ctrl_zero;
    next_irq_ctrl_one = irq_ctrl_one;
    next_irq_ctrl_two = irq_ctrl_two;
    next_irq_ctrl_three = irq_ctrl_three;
    next_shared_source_zero = shared_source_zero;
    next_sys_status = sys_status;
    next_sys_enable = sys_enable;
    // Software writes first, hardware sets override
    if (wr_en) begin
      if (waddr == `OFF_EDGE_SELECT) begin
        next_edge_select = wbyte & `MASK_EDGE_SELECT;
      end else if (waddr == `OFF_IRQ_CTRL_ZERO) begin
        next_irq_ctrl_zero = wbyte & `MASK_IRQ_CTRL_ZERO;
      end else if (waddr == `OFF_IRQ_CTRL_ONE) begin
        next_irq_ctrl_one = wbyte & `MASK_IRQ_CTRL_ONE;
      end else if (waddr == `OFF_IRQ_CTRL_TWO) begin
        next_irq_ctrl_two = wbyte & `MASK_IRQ_CTRL_TWO;
      end else if (waddr == `OFF_IRQ_CTRL_THREE) begin
        next_irq_ctrl_three = wbyte & `MASK_IRQ_CTRL_THREE;
      end else if (waddr == `OFF_SHARED_SOURCE_ZERO) begin
        next_shared_source_zero = wbyte & `MASK_SHARED_SOURCE_ZERO;
      end else if (waddr == `OFF_SYS_CLEAR) begin
        next_sys_status = sys_status & ~wbyte[1:0];
      end else if (waddr == `OFF_SYS_ENABLE) begin
        next_sys_enable = wbyte[1:0];
      end
    end
    // Service acknowledge from the core
    if (svc) begin
      next_irq_ctrl_zero[`BIT_GLOBAL_EN] = 1'b0;
      if (service_source == 4'h0) begin
        next_irq_ctrl_zero[`BIT_PIN0_FLAG] = 1'b0;
      end else if (service_source == 4'h1) begin
        next_irq_ctrl_zero[`BIT_PIN1_FLAG] = 1'b0;
      end
    end
    // Hardware event sets, winning over clears
    if (pin0_hit) next_irq_ctrl_zero[`BIT_PIN0_FLAG] = 1'b1;
    if (pin1_hit) next_irq_ctrl_zero[`BIT_PIN1_FLAG] = 1'b1;
    if (overcurrent_event) next_irq_ctrl_zero[`BIT_OC_FLAG] = 1'b1;
    if (overheat_event) next_irq_ctrl_one[`BIT_HOT_FLAG] = 1'b1;
    if (ir_sense_event) next_irq_ctrl_one[`BIT_IR_FLAG] = 1'b1;
    if (adc_done_event) next_irq_ctrl_one[`BIT_ADC_FLAG] = 1'b1;
    if (eeprom_write_event) next_irq_ctrl_three[`BIT_EEP_FLAG] = 1'b1;
    if (low_supply_event) next_irq_ctrl_three[`BIT_LOW_FLAG] = 1'b1;
    if (timer_c_match_a_event) next_shared_source_zero[`BIT_TC_A_FLAG] = 1'b1;
    if (timer_c_match_p_event) next_shared_source_zero[`BIT_TC_P_FLAG] = 1'b1;
    if (group0_src) next_irq_ctrl_two[4] = 1'b1;
    if (group_event[1]) next_irq_ctrl_two[5] = 1'b1;
    if (group_event[2]) next_irq_ctrl_two[6] = 1'b1;
    if (group_event[3]) next_irq_ctrl_two[7] = 1'b1;
    // System status: bit 0 request pending, bit 1 service taken
    if (core_irq_request) next_sys_status[0] = 1'b1;
    if (svc) next_sys_status[1] = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      edge_select <= `RESET_BYTE;
      irq_ctrl_zero <= `RESET_BYTE;
      irq_ctrl_one <= `RESET_BYTE;
      irq_ctrl_two <= `RESET_BYTE;
      irq_ctrl_three <= `RESET_BYTE;
      shared_source_zero <= `RESET_BYTE;
      sys_status <= 2'h0;
      sys_enable <= 2'h0;
    end else begin
      edge_select <= next_edge_select;
      irq_ctrl_zero <= next_irq_ctrl_zero;
      irq_ctrl_one <= next_irq_ctrl_one;
      irq_ctrl_two <= next_irq_ctrl_two;
      irq_ctrl_three <= next_irq_ctrl_three;
      shared_source_zero <= next_shared_source_zero;
      sys_status <= next_sys_status;
      sys_enable <= next_sys_enable;
    end
  end

  assign irq = |(sys_status & sys_enable);
endmodule

// [sim/irq_bank_checker_assertions.sv]
// Concurrent checks on the interrupt flag bank ports
// Bound to every irq_flag_bank instance; one clock domain
`timescale 1ns/10ps
module irq_bank_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Events and core side
  input wire logic pin0,
  input wire logic pin1,
  input wire logic overcurrent_event,
  input wire logic overheat_event,
  input wire logic ir_sense_event,
  input wire logic adc_done_event,
  input wire logic eeprom_write_event,
  input wire logic low_supply_event,
  input wire logic timer_c_match_a_event,
  input wire logic timer_c_match_p_event,
  input wire logic [3:1] group_event,
  input wire logic core_irq_request,
  input wire logic service_ack,
  input wire logic irq
);
  logic any_event;
  logic wr_beat;
  assign any_event = overcurrent_event | overheat_event | ir_sense_event | adc_done_event |
    eeprom_write_event | low_supply_event | timer_c_match_a_event | timer_c_match_p_event |
    (|group_event);
  assign wr_beat = s_axi_wvalid & s_axi_wready;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_reset_idle;
    disable iff (1'b0) !resetn |=> !s_axi_bvalid && !s_axi_rvalid && !core_irq_request && !irq;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");
  property p_req_cause;
    $rose(core_irq_request) |-> $past(any_event) || $past(any_event, 2) || $past(wr_beat) ||
      $past(wr_beat, 2) || ($past(pin0) != $past(pin0, 2)) || ($past(pin1) != $past(pin1, 2));
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("request without cause");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no write response");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no read response");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h24 || s_axi_araddr[1:0] != 2'b00)
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_service;
    service_ack && !s_axi_wvalid |=> !core_irq_request;
  endproperty
  a_service: assert property (p_service) else $error("request after service");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped");
  property p_refuse;
    s_axi_bvalid || s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("read taken while busy");
endmodule

bind irq_flag_bank irq_bank_checker u_chk (.clock(clock), .resetn(resetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin0(pin0), .pin1(pin1),
  .overcurrent_event(overcurrent_event), .overheat_event(overheat_event),
  .ir_sense_event(ir_sense_event), .adc_done_event(adc_done_event),
  .eeprom_write_event(eeprom_write_event), .low_supply_event(low_supply_event),
  .timer_c_match_a_event(timer_c_match_a_event),
  .timer_c_match_p_event(timer_c_match_p_event), .group_event(group_event),
  .core_irq_request(core_irq_request), .service_ack(service_ack), .irq(irq));

// [sim/core_seq_model.sv]
// Core sequencer model: takes a pending request after a set lag
// Assumes pick and lag are held steady by the bench while a request waits
`timescale 1ns/10ps
module core_seq_model (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Request and bench controls
  input wire logic core_irq_request,
  input wire logic [3:0] pick,
  input wire logic [3:0] lag,
  // Service answer
  output logic service_ack,
  output logic [3:0] service_source
);
  logic [3:0] wait_count;
  logic [3:0] next_wait_count;
  logic next_ack;
  always_comb begin
    next_ack = 1'b0;
    next_wait_count = 4'h0;
    if (core_irq_request && !service_ack) begin
      if (wait_count == lag) begin
        next_ack = 1'b1;
      end else begin
        next_wait_count = wait_count + 4'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      service_ack <= 1'b0;
      wait_count <= 4'h0;
    end else begin
      service_ack <= next_ack;
      wait_count <= next_wait_count;
    end
  end
  // Source is only meaningful with the acknowledge
  assign service_source = service_ack ? pick : ~pick;
endmodule

// [sim/test_mcu_interrupt_flag_enable_bank.sv]
// Self-checking bench of the interrupt flag bank
// Drives the register bus, pins and events; core model answers requests
`timescale 1ns/10ps
module test_mcu_interrupt_flag_enable_bank;
  logic clock, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  wire logic awready, wready, bvalid, arready, rvalid, core_irq_request, service_ack, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0] service_source;
  logic [1:0] pins;
  logic [10:0] ev;
  logic [3:0] pick, lag;
  int n_mismatch, checked;
  logic [7:0] m [6];
  logic [7:0] mask [6] = '{8'h0f, 8'h7f, 8'hee, 8'hff, 8'hdd, 8'h33};
  int ri [11] = '{1, 2, 2, 2, 4, 4, 5, 5, 3, 3, 3};
  int bi [11] = '{6, 5, 6, 7, 6, 4, 5, 4, 5, 6, 7};
  irq_flag_bank DUT (.clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin0(pins[0]), .pin1(pins[1]), .overcurrent_event(ev[0]),
    .overheat_event(ev[1]), .ir_sense_event(ev[2]), .adc_done_event(ev[3]),
    .eeprom_write_event(ev[4]), .low_supply_event(ev[5]), .timer_c_match_a_event(ev[6]),
    .timer_c_match_p_event(ev[7]), .group_event(ev[10:8]), .core_irq_request(core_irq_request),
    .service_ack(service_ack), .service_source(service_source), .irq(irq));
  core_seq_model u_core (.clock(clock), .resetn(resetn), .core_irq_request(core_irq_request),
    .pick(pick), .lag(lag), .service_ack(service_ack), .service_source(service_source));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit ad, wd;
    ad = 0;
    wd = 0;
    n = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd) && n < 40) begin
      @(posedge clock);
      n++;
      if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 1'b0; end
      if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 1'b0; end
    end
    bready <= 1'b1;
    do begin @(posedge clock); n++; end while (bvalid !== 1'b1 && n < 40);
    cmp("bresp", {30'h0, er}, {30'h0, bresp});
    if (n >= 40) n_mismatch++;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    int n;
    n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin @(posedge clock); n++; end while (arready !== 1'b1 && n < 40);
    arvalid <= 1'b0;
    do begin @(posedge clock); n++; end while (rvalid !== 1'b1 && n < 40);
    cmp("rdata", ed, rdata);
    cmp("rresp", {30'h0, er}, {30'h0, rresp});
    if (n >= 40) n_mismatch++;
    rready <= 1'b0;
  endtask
  task automatic wait_ack;
    int n;
    n = 0;
    while (service_ack !== 1'b1 && n < 30) begin @(posedge clock); n++; end
    if (n >= 30) n_mismatch++;
    cmp("request", 32'h1, {31'h0, core_irq_request});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    {resetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {pins, ev, pick, lag} = '0;
    void'($urandom(10093));
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      if (i == 1) d[0] = 1'b0;
      wr(8'(4 * i), d, 2'b00);
      m[i] = d[7:0] & mask[i];
      if (m[5][5:4] & m[5][1:0]) m[3][4] = 1'b1;
    end
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 2'b00, {24'h0, m[i]});
    wr(8'h2c, $urandom, 2'b10);
    rd(8'h28, 2'b10, 32'h0);
    rd(8'h05, 2'b10, 32'h0);
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 2'b00, 32'h0);
    $display("test registers done");
    for (int p = 0; p < 2; p++) for (int md = 0; md < 4; md++) begin
      wr(8'h00, 32'(md << (2 * p)), 2'b00);
      @(posedge clock);
      pins[p] <= 1'b1;
      rd(8'h04, 2'b00, 32'((md % 2) << (4 + p)));
      wr(8'h04, 32'h0, 2'b00);
      @(posedge clock);
      pins[p] <= 1'b0;
      rd(8'h04, 2'b00, 32'((md / 2) << (4 + p)));
      wr(8'h04, 32'h0, 2'b00);
    end
    $display("test edges done");
    for (int k = 0; k < 11; k++) begin
      @(posedge clock);
      ev[k] <= 1'b1;
      @(posedge clock);
      ev <= 11'h0;
      rd(8'(4 * ri[k]), 2'b00, 32'(1 << bi[k]));
      cmp("request", 32'h0, {31'h0, core_irq_request});
      wr(8'(4 * ri[k]), 32'h0, 2'b00);
    end
    $display("test events done");
    wr(8'h00, 32'h1, 2'b00);
    wr(8'h04, 32'h3, 2'b00);
    @(posedge clock);
    pins[0] <= 1'b1;
    wait_ack();
    rd(8'h04, 2'b00, 32'h02);
    pins[0] <= 1'b0;
    wr(8'h04, 32'h0a, 2'b00);
    @(posedge clock);
    ev[0] <= 1'b1;
    @(posedge clock);
    ev[0] <= 1'b0;
    rd(8'h04, 2'b00, 32'h4a);
    cmp("request", 32'h0, {31'h0, core_irq_request});
    lag <= 4'h5;
    pick <= 4'h2;
    wr(8'h04, 32'h4b, 2'b00);
    rd(8'h18, 2'b00, 32'h1);
    wait_ack();
    rd(8'h04, 2'b00, 32'h4a);
    $display("test service done");
    wr(8'h24, 32'h3, 2'b00);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(8'h24, 32'h0, 2'b00);
    cmp("irq", 32'h0, {31'h0, irq});
    wr(8'h24, 32'h3, 2'b00);
    wr(8'h20, 32'h3, 2'b00);
    cmp("irq", 32'h0, {31'h0, irq});
    rd(8'h1c, 2'b00, 32'h0);
    rd(8'h20, 2'b00, 32'h0);
    $display("test system interrupt done");
    conclude();
  end
endmodule
